// File: test_trigger_and_selftest_control.sv
`timescale 1ns/1ps
`include "tstc_consts.vh"
module test_trigger_and_selftest_control;
	reg         clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, qe;
	reg  [11:0] paddr = 0;
	reg  [31:0] pwdata = 0, q;
	reg  [15:0] fail = 0;
	reg  [3:0]  asi = 0, info = 0, sel = 0;
	wire [31:0] prdata;
	wire        pready, pslverr, fire_pulse, oen, ozero, waitg, busy, term;
	wire [7:0]  lines, tout, toe;
	integer     num_errors = 0, samples_checked = 0, nfire = 0, seed = 37, i, k;
	always #20 clk = ~clk;
	always @(posedge clk) if (fire_pulse === 1'b1) nfire <= nfire + 1;
	tstc_top i_tstc_top (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .backplane_trigger_lines(lines),
		.terminal_trigger_in(term), .test_fail_in(fail), .test_info_in(info),
		.address_space_info(asi), .backplane_trigger_output(tout), .backplane_trigger_oe(toe),
		.fire_pulse(fire_pulse), .outputs_enabled(oen), .outputs_zero(ozero),
		.waiting_trigger(waitg), .selftest_busy(busy));
	tstc_trig_drv i_tstc_trig_drv (.clk(clk), .line_sel(sel), .go(go), .lines(lines),
		.term(term));
	task print_verdict;
		begin
			if (num_errors == 0 && samples_checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk);
			psel <= 1;
			penable <= 0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 30);
			q = prdata;
			qe = pslverr;
			psel <= 0;
			penable <= 0;
			if (pready !== 1'b1) begin
				chk("pready", 1, pready);
				print_verdict;
			end
		end
	endtask
	task cmd(input integer b);
		apb(1, `TSTC_OFF_CMD, 32'h1 << b);
	endtask
	task err(input [31:0] e);
		begin
			apb(0, `TSTC_OFF_ERR, 0);
			chk("err", e, q);
			apb(1, `TSTC_OFF_ERR, 32'h1F);
		end
	endtask
	task wfire(input integer n0);
		integer n;
		begin
			for (n = 0; n < 20 && nfire == n0; n = n + 1) @(posedge clk);
			chk("fire", 1, nfire > n0);
		end
	endtask
	task idle;
		integer n;
		begin
			q = 4;
			for (n = 0; n < 200 && q[3:2] !== 2'b10; n = n + 1) apb(0, `TSTC_OFF_STATUS, 0);
			chk("idle", 2, q[3:2]);
		end
	endtask
	function [31:0] name_of(input [3:0] c);
		case (c)
			4'h8: name_of = 32'h0053_5542;
			4'h9: name_of = 32'h444C_4F48;
			4'hA: name_of = 32'h004D_4D49;
			4'hB: name_of = 32'h0054_5845;
			default: name_of = {8'h30 + c, 24'h4C_5454};
		endcase
	endfunction
	initial begin
		asi <= $random(seed);
		info <= $random(seed);
		fail <= 16'h0001;
		repeat (6) @(posedge clk);
		rst_n <= 1;
		idle;
		cmd(`TSTC_CMD_SELFTEST);
		idle;
		apb(0, `TSTC_OFF_SUMMARY, 0);
		chk("sum", {8'd1, asi, info}, q);
		for (i = 1; i <= 100; i = i + 33) begin
			apb(0, `TSTC_OFF_RESULTS + 12'(4 * i - 4), 0);
			chk("word", i > 75 ? 0 : {i[7:0], asi, info}, q);
		end
		apb(0, 12'h020, 0);
		chk("slverr", 1, qe);
		apb(1, `TSTC_OFF_OUTCTL, 32'h0000_A55A);
		@(posedge clk);
		chk("tout", 8'h5A, tout);
		chk("toe", 8'hA5, toe);
		apb(0, `TSTC_OFF_OUTCTL, 0);
		chk("outctl", 32'h0000_A55A, q);
		for (k = 0; k < 12; k = k + 1) begin
			apb(1, `TSTC_OFF_SRC, k);
			apb(0, `TSTC_OFF_SRC_NAME, 0);
			chk("name", name_of(k[3:0]), q);
		end
		apb(1, `TSTC_OFF_SRC, 12);
		err(1 << `TSTC_ERR_SRC_BAD);
		cmd(`TSTC_CMD_FIRE_NOW);
		err(1 << `TSTC_ERR_FIRE_IDLE);
		for (i = 1; i < 4; i = i + 1) begin
			apb(1, `TSTC_OFF_SRC, i == 3 ? `TSTC_SRC_HOLD : `TSTC_SRC_BUS);
			cmd(`TSTC_CMD_ARM);
			k = nfire;
			cmd(i);
			wfire(k);
			apb(0, `TSTC_OFF_STATUS, 0);
			chk("rearm", 1, q[1:0]);
		end
		for (i = 0; i < 2; i = i + 1) begin
			sel = i ? 4'hB : {$random(seed)} % 8;
			apb(1, `TSTC_OFF_SRC, sel);
			cmd(`TSTC_CMD_ARM);
			cmd(`TSTC_CMD_FIRE_NOW);
			err(1 << `TSTC_ERR_FIRE_SRC);
			apb(1, `TSTC_OFF_SRC, `TSTC_SRC_HOLD);
			err(1 << `TSTC_ERR_SRC_BUSY);
			cmd(`TSTC_CMD_SELFTEST);
			err(1 << `TSTC_ERR_TEST_BUSY);
			k = nfire;
			go <= 1;
			@(posedge clk);
			go <= 0;
			wfire(k);
			repeat (10) @(posedge clk);
			chk("once", k + 1, nfire);
		end
		apb(1, `TSTC_OFF_SRC, `TSTC_SRC_AUTO);
		k = nfire;
		cmd(`TSTC_CMD_ARM);
		wfire(k);
		chk("waitg", 1, waitg);
		cmd(`TSTC_CMD_FIRE_NOW);
		err(1 << `TSTC_ERR_FIRE_SRC);
		cmd(`TSTC_CMD_ABORT);
		chk("outen1", 1, oen);
		fail <= 16'h0000;
		cmd(`TSTC_CMD_SELFTEST);
		idle;
		apb(0, `TSTC_OFF_SUMMARY, 0);
		chk("sum", 0, q);
		chk("outen", 0, oen);
		chk("ozero", 1, ozero);
		chk("busy", 0, busy);
		cmd(`TSTC_CMD_RESET);
		apb(0, `TSTC_OFF_CMD, 0);
		chk("src", `TSTC_SRC_RESET, q);
		print_verdict;
	end
endmodule
bind tstc_top tstc_asserts i_tstc_asserts (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .fire_pulse(fire_pulse),
	.outputs_enabled(outputs_enabled), .outputs_zero(outputs_zero),
	.waiting_trigger(waiting_trigger), .selftest_busy(selftest_busy));

// File: tstc_asserts.sv
`timescale 1ns/1ps
module tstc_asserts (
	input wire clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire fire_pulse,
	input wire outputs_enabled,
	input wire outputs_zero,
	input wire waiting_trigger,
	input wire selftest_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	apb_answer_a: assert property (psel && !penable |=> pready) else $error("no pready");
	ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
	err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
	fire_enables_a: assert property (fire_pulse |-> ##[0:1] outputs_enabled) else $error("no enable");
	zero_inverse_a: assert property (outputs_zero != outputs_enabled) else $error("zero level");
	test_disables_a: assert property ($fell(selftest_busy) |-> !outputs_enabled) else $error("out on");
	test_not_wait_a: assert property (selftest_busy |-> !waiting_trigger) else $error("test in wait");
	post_runs_a: assert property ($rose(rst_n) |-> selftest_busy[*8]) else $error("no post");
	post_ends_a: assert property ($rose(rst_n) |-> ##[20:40] !selftest_busy) else $error("post hang");
endmodule

// File: tstc_consts.vh
`ifndef TSTC_CONSTS_VH
`define TSTC_CONSTS_VH

// APB register byte offsets
`define TSTC_OFF_CMD       12'h000
`define TSTC_OFF_SRC       12'h004
`define TSTC_OFF_STATUS    12'h008
`define TSTC_OFF_SUMMARY   12'h00C
`define TSTC_OFF_ERR       12'h010
`define TSTC_OFF_OUTCTL    12'h014
`define TSTC_OFF_SRC_NAME  12'h018
`define TSTC_OFF_RESULTS   12'h400
`define TSTC_RESULTS_LAST  12'h58C

// Command register bits
`define TSTC_CMD_ARM       0
`define TSTC_CMD_FIRE_NOW  1
`define TSTC_CMD_COMMON    2
`define TSTC_CMD_GET       3
`define TSTC_CMD_SELFTEST  4
`define TSTC_CMD_RESET     5
`define TSTC_CMD_ABORT     6

// Trigger source codes
`define TSTC_SRC_TTL0      4'h0
`define TSTC_SRC_BUS       4'h8
`define TSTC_SRC_HOLD      4'h9
`define TSTC_SRC_AUTO      4'hA
`define TSTC_SRC_TERM      4'hB
`define TSTC_SRC_RESET     4'h9

// Error bits
`define TSTC_ERR_TEST_BUSY 0
`define TSTC_ERR_FIRE_SRC  1
`define TSTC_ERR_FIRE_IDLE 2
`define TSTC_ERR_SRC_BUSY  3
`define TSTC_ERR_SRC_BAD   4

// Self-test layout
`define TSTC_NUM_TESTS     7'd75
`define TSTC_NUM_WORDS     7'd100
`define TSTC_POST_LAST     7'd25
`define TSTC_TNUM_MSB      15
`define TSTC_TNUM_LSB      8
`define TSTC_ASI_MSB       7
`define TSTC_ASI_LSB       4
`define TSTC_INFO_MSB      3
`define TSTC_INFO_LSB      0

`endif

// File: tstc_edge_detect.v
`timescale 1ns/1ps
module tstc_edge_detect (
	input  wire clk,
	input  wire rst_n,
	input  wire din,
	output reg  rise
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			rise   <= 1'b0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// One pulse per rising edge
			rise   <= s2_reg & ~s3_reg;
		end
	end
endmodule

// File: tstc_top.v
`timescale 1ns/1ps
`include "tstc_consts.vh"
module tstc_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [7:0]  backplane_trigger_lines,
	input  wire        terminal_trigger_in,
	input  wire [15:0] test_fail_in,
	input  wire [3:0]  test_info_in,
	input  wire [3:0]  address_space_info,
	output reg  [7:0]  backplane_trigger_output,
	output reg  [7:0]  backplane_trigger_oe,
	output reg         fire_pulse,
	output reg         outputs_enabled,
	output reg         outputs_zero,
	output reg         waiting_trigger,
	output reg         selftest_busy
);
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_TEST = 2'd2;

	reg [1:0]  state_reg;
	reg [3:0]  src_reg;
	reg [15:0] summary_reg;
	reg [4:0]  err_reg;
	reg [6:0]  tnum_reg;
	reg [6:0]  tlast_reg;
	reg        post_done_reg;
	reg        full_run_reg;
	reg [15:0] results [0:99];
	reg [7:0]  line_rise;
	reg        fire_ev;
	reg        sel_rise;
	integer    i;

	wire       wr_en = psel & penable & pwrite;
	wire       rd_en = psel & penable & ~pwrite;
	wire       cmd_wr = wr_en && (paddr == `TSTC_OFF_CMD);
	wire       src_wr = wr_en && (paddr == `TSTC_OFF_SRC);
	wire       sw_src = (src_reg == `TSTC_SRC_BUS) || (src_reg == `TSTC_SRC_HOLD);
	wire [6:0] res_idx = paddr[8:2] + 7'd0;
	wire       res_hit = (paddr >= `TSTC_OFF_RESULTS) && (paddr <= `TSTC_RESULTS_LAST);

	// Result word layout, shared by summary and report
	function [15:0] pack_word;
		input [6:0] num;
		input [3:0] asi;
		input [3:0] info;
		begin
			pack_word = 16'h0000;
			pack_word[`TSTC_TNUM_MSB:`TSTC_TNUM_LSB] = {1'b0, num};
			pack_word[`TSTC_ASI_MSB:`TSTC_ASI_LSB] = asi;
			pack_word[`TSTC_INFO_MSB:`TSTC_INFO_LSB] = info;
		end
	endfunction

	// Token text packed as ASCII, low byte first
	function [31:0] src_token;
		input [3:0] s;
		begin
			if (s < `TSTC_SRC_BUS)
				src_token = {4'h3, 1'b0, s[2:0], 8'h4C, 8'h54, 8'h54};
			else if (s == `TSTC_SRC_BUS)
				src_token = 32'h0053_5542;
			else if (s == `TSTC_SRC_HOLD)
				src_token = 32'h444C_4F48;
			else if (s == `TSTC_SRC_AUTO)
				src_token = 32'h004D_4D49;
			else
				src_token = 32'h0054_5845;
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_sync
			tstc_edge_detect u_ed (
				.clk  (clk),
				.rst_n(rst_n),
				.din  (backplane_trigger_lines[g]),
				.rise (line_rise[g])
			);
		end
	endgenerate

	wire term_rise;
	tstc_edge_detect u_term (
		.clk  (clk),
		.rst_n(rst_n),
		.din  (terminal_trigger_in),
		.rise (term_rise)
	);

	always @* begin
		sel_rise = 1'b0;
		if (src_reg < `TSTC_SRC_BUS)
			sel_rise = line_rise[src_reg[2:0]];
		else if (src_reg == `TSTC_SRC_TERM)
			sel_rise = term_rise;
		fire_ev = 1'b0;
		if (state_reg == ST_WAIT) begin
			if (src_reg == `TSTC_SRC_AUTO)
				fire_ev = 1'b1;
			else if (sw_src)
				fire_ev = cmd_wr && (pwdata[`TSTC_CMD_FIRE_NOW] ||
					pwdata[`TSTC_CMD_COMMON] || pwdata[`TSTC_CMD_GET]);
			else
				fire_ev = sel_rise;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg       <= ST_TEST;
			src_reg         <= `TSTC_SRC_RESET;
			summary_reg     <= 16'h0000;
			err_reg         <= 5'd0;
			tnum_reg        <= 7'd1;
			tlast_reg       <= `TSTC_POST_LAST;
			post_done_reg   <= 1'b0;
			full_run_reg    <= 1'b0;
			fire_pulse      <= 1'b0;
			outputs_enabled <= 1'b0;
			outputs_zero    <= 1'b1;
			backplane_trigger_output <= 8'h00;
			backplane_trigger_oe     <= 8'h00;
		end else begin
			fire_pulse <= 1'b0;
			if (wr_en && paddr == `TSTC_OFF_ERR)
				err_reg <= err_reg & ~pwdata[4:0];
			if (wr_en && paddr == `TSTC_OFF_OUTCTL) begin
				backplane_trigger_output <= pwdata[7:0];
				backplane_trigger_oe     <= pwdata[15:8];
			end
			case (state_reg)
			ST_IDLE: begin
				if (cmd_wr && pwdata[`TSTC_CMD_FIRE_NOW])
					err_reg[`TSTC_ERR_FIRE_IDLE] <= 1'b1;
				if (cmd_wr && pwdata[`TSTC_CMD_RESET]) begin
					src_reg         <= `TSTC_SRC_RESET;
					outputs_enabled <= 1'b0;
					outputs_zero    <= 1'b1;
				end else if (cmd_wr && pwdata[`TSTC_CMD_SELFTEST]) begin
					state_reg    <= ST_TEST;
					tnum_reg     <= 7'd1;
					tlast_reg    <= `TSTC_NUM_TESTS;
					full_run_reg <= 1'b1;
					summary_reg  <= 16'h0000;
				end else if (cmd_wr && pwdata[`TSTC_CMD_ARM]) begin
					state_reg <= ST_WAIT;
				end else if (src_wr) begin
					if (pwdata[3:0] <= `TSTC_SRC_TERM)
						src_reg <= pwdata[3:0];
					else
						err_reg[`TSTC_ERR_SRC_BAD] <= 1'b1;
				end
			end
			ST_WAIT: begin
				if (src_wr)
					err_reg[`TSTC_ERR_SRC_BUSY] <= 1'b1;
				if (cmd_wr && pwdata[`TSTC_CMD_SELFTEST])
					err_reg[`TSTC_ERR_TEST_BUSY] <= 1'b1;
				if (cmd_wr && pwdata[`TSTC_CMD_FIRE_NOW] && !sw_src)
					err_reg[`TSTC_ERR_FIRE_SRC] <= 1'b1;
				if (cmd_wr && pwdata[`TSTC_CMD_ABORT]) begin
					state_reg <= ST_IDLE;
				end else if (fire_ev) begin
					fire_pulse      <= 1'b1;
					outputs_enabled <= 1'b1;
					outputs_zero    <= 1'b0;
					// Auto-fire stays armed, others need a new arm
					if (src_reg != `TSTC_SRC_AUTO)
						state_reg <= ST_IDLE;
				end
			end
			ST_TEST: begin
				// One test per clock; only bit 0 reports the current test
				if (cmd_wr && pwdata[`TSTC_CMD_FIRE_NOW])
					err_reg[`TSTC_ERR_FIRE_IDLE] <= 1'b1;
				if (tnum_reg == tlast_reg) begin
					state_reg       <= ST_IDLE;
					full_run_reg    <= 1'b0;
					post_done_reg   <= 1'b1;
					outputs_enabled <= 1'b0;
					outputs_zero    <= 1'b1;
				end
				tnum_reg <= tnum_reg + 7'd1;
				if (test_fail_in[0] && summary_reg == 16'h0000)
					summary_reg <= pack_word(tnum_reg, address_space_info,
						test_info_in);
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Report array; test n lands in slot n-1
	always @(posedge clk) begin
		if (!rst_n) begin
			for (i = 0; i < 100; i = i + 1)
				results[i] <= 16'h0000;
		end else if (state_reg == ST_TEST) begin
			if (tnum_reg == 7'd1 && full_run_reg)
				for (i = 1; i < 100; i = i + 1)
					results[i] <= 16'h0000;
			results[tnum_reg - 7'd1] <= test_fail_in[0] ?
				pack_word(tnum_reg, address_space_info, test_info_in) : 16'h0000;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			prdata          <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
			waiting_trigger <= 1'b0;
			selftest_busy   <= 1'b1;
		end else begin
			waiting_trigger <= (state_reg == ST_WAIT);
			selftest_busy   <= (state_reg == ST_TEST);
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == `TSTC_OFF_CMD || paddr == `TSTC_OFF_SRC)
					prdata <= {28'h000_0000, src_reg};
				else if (paddr == `TSTC_OFF_STATUS)
					prdata <= {28'h000_0000, post_done_reg, state_reg == ST_TEST,
						state_reg == ST_WAIT, outputs_enabled};
				else if (paddr == `TSTC_OFF_SUMMARY)
					prdata <= {16'h0000, summary_reg};
				else if (paddr == `TSTC_OFF_ERR)
					prdata <= {27'h000_0000, err_reg};
				else if (paddr == `TSTC_OFF_OUTCTL)
					prdata <= {16'h0000, backplane_trigger_oe, backplane_trigger_output};
				else if (paddr == `TSTC_OFF_SRC_NAME)
					prdata <= src_token(src_reg);
				else if (res_hit)
					prdata <= {{16{results[res_idx][15]}}, results[res_idx]};
				else
					pslverr <= 1'b1;
			end
		end
	end
endmodule

// File: tstc_trig_drv.sv
`timescale 1ns/1ps
module tstc_trig_drv (
	input  wire       clk,
	input  wire [3:0] line_sel,
	input  wire       go,
	output reg  [7:0] lines,
	output reg        term
);
	reg  [1:0] hold_reg;
	wire       on = go || hold_reg > 2'd1;
	initial begin
		lines = 8'h00;
		term = 1'b0;
		hold_reg = 2'd0;
	end
	// Lines pulled low when not pulsed
	always @(posedge clk) begin
		if (go)
			hold_reg <= 2'd3;
		else if (hold_reg != 2'd0)
			hold_reg <= hold_reg - 2'd1;
		lines <= (on && line_sel < 4'd8) ? (8'h01 << line_sel[2:0]) : 8'h00;
		term <= on && line_sel == 4'hB;
	end
endmodule
